// >>> acb_pkg.sv
// Purpose: shared constants for the converter configuration register bank
// Assumes: byte-wide registers behind a 4-wire serial port, 15-bit addresses
// Notes:   identification values are parameters of the top module, not here
`default_nettype none

package acb_pkg;

  // register addresses
  localparam logic [14:0] ADDR_IFACE      = 15'h0000;
  localparam logic [14:0] ADDR_PWR        = 15'h0002;
  localparam logic [14:0] ADDR_CLASS      = 15'h0003;
  localparam logic [14:0] ADDR_PART_LO    = 15'h0004;
  localparam logic [14:0] ADDR_PART_HI    = 15'h0005;
  localparam logic [14:0] ADDR_REVISION   = 15'h0006;
  localparam logic [14:0] ADDR_MAKER_LO   = 15'h000c;
  localparam logic [14:0] ADDR_MAKER_HI   = 15'h000d;
  localparam logic [14:0] ADDR_LEVEL      = 15'h0010;
  localparam logic [14:0] ADDR_OM1        = 15'h0012;
  localparam logic [14:0] ADDR_OM2        = 15'h0013;

  // reset values
  localparam logic [7:0]  IFACE_RST       = 8'h3c;
  localparam logic [7:0]  PWR_RST         = 8'h00;
  localparam logic [3:0]  CLASS_HI_RST    = 4'h0;
  localparam logic [7:0]  LEVEL_RST       = 8'h01;
  localparam logic [7:0]  OM1_RST         = 8'h81;
  localparam logic [7:0]  OM2_RST         = 8'h20;

  // interface_config field positions
  localparam int          IFACE_SRST_BIT  = 7;
  localparam int          IFACE_RSVD6_BIT = 6;
  localparam int          IFACE_STEP_BIT  = 5;

  // operating mode field positions
  localparam int          OM1_FMT_BIT     = 7;
  localparam int          OM1_IDLE_LSB    = 3;
  localparam int          OM1_GATE_BIT    = 2;
  localparam int          OM2_DIV_LSB     = 3;

  // power state codes
  localparam logic [1:0]  PWR_NORMAL      = 2'h0;
  localparam logic [1:0]  PWR_SLEEP       = 2'h2;
  localparam logic [1:0]  PWR_DOWN        = 2'h3;

  // reference pulse idle codes
  localparam logic [1:0]  IDLE_NONE       = 2'h0;
  localparam logic [1:0]  IDLE_LOW        = 2'h1;
  localparam logic [1:0]  IDLE_HIGH       = 2'h2;

  // sample clock divider codes and terminal counts
  localparam logic [1:0]  DIV_BY1         = 2'h0;
  localparam logic [1:0]  DIV_BY2         = 2'h1;
  localparam logic [1:0]  DIV_BY4         = 2'h2;
  localparam logic [1:0]  DIV_BY8         = 2'h3;
  localparam logic [2:0]  DIV_LAST1       = 3'h0;
  localparam logic [2:0]  DIV_LAST2       = 3'h1;
  localparam logic [2:0]  DIV_LAST4       = 3'h3;
  localparam logic [2:0]  DIV_LAST8       = 3'h7;

  // serial frame: read/write flag, 15 address bits, then data bytes
  localparam int          HDR_RW_BIT      = 15;
  localparam logic [3:0]  HDR_LAST        = 4'hf;
  localparam logic [3:0]  DATA_LAST       = 4'h7;

  typedef enum logic [2:0] {
    ACB_IDLE   = 3'b001,
    ACB_HEADER = 3'b010,
    ACB_DATA   = 3'b100
  } acb_spi_state_e;

endpackage

`default_nettype wire

// >>> acb_clk_div.sv
// Purpose: sampling clock divider, one strobe every 1, 2, 4 or 8 clocks
// Assumes: ratio code may change at any time
// Notes:   a ratio change takes effect at the next terminal count or sooner
`timescale 1ns/10ps
`default_nettype none

module acb_clk_div (
  input  wire logic       clk,           // system clock
  input  wire logic       srst,          // synchronous reset, active high
  input  wire logic [1:0] ratio,         // divider code
  output var  logic       sample_strobe  // one-cycle sample enable
);

  logic [2:0] count;
  logic [2:0] last;

  always_comb begin
    case (ratio)
      acb_pkg::DIV_BY1: last = acb_pkg::DIV_LAST1;
      acb_pkg::DIV_BY2: last = acb_pkg::DIV_LAST2;
      acb_pkg::DIV_BY4: last = acb_pkg::DIV_LAST4;
      acb_pkg::DIV_BY8: last = acb_pkg::DIV_LAST8;
      default:          last = acb_pkg::DIV_LAST1;
    endcase
  end

  // >= so that shrinking the ratio never strands the counter above it
  always_ff @(posedge clk) begin
    if (srst) begin
      count         <= 3'h0;
      sample_strobe <= 1'b0;
    end else if (count >= last) begin
      count         <= 3'h0;
      sample_strobe <= 1'b1;
    end else begin
      count         <= count + 3'h1;
      sample_strobe <= 1'b0;
    end
  end

endmodule // acb_clk_div

`default_nettype wire

// >>> acb_reg_bank.sv
// Purpose: configuration and identification register bank behind a 4-wire serial port
// Assumes: serial pins are synchronous to clk and sclk is well below clk/4
// Notes:   frame is r/w flag, 15-bit address, data bytes streamed while csb is low
//
// Notes on behaviour
// - soft reset bit restores defaults, self-clears
// - streaming address steps up or down
// - low nibble mirrors high nibble of interface_config
// - power field: normal, sleep, power-down
// - read-only part class code in low nibble
// - part code low byte 0x4, high 0x5
// - maker code low byte 0xc, high 0xd
// - serial-output level select drives output swing
// - bit 7 picks offset binary or two's complement
// - reference pulse idle offset select, 11 reserved
// - reference pulse ignored unless gate enabled
// - sampling clock divided by 1, 2, 4, 8
// - second operating mode at 0x13, reset 0x20
// - power changes keep registers; power-down exit calibrates
// - serial output driven only in read data
`timescale 1ns/10ps
`default_nettype none

module acb_reg_bank #(
  parameter logic [3:0]  PART_CLASS_CODE = 4'h9,    // arbitrary value
  parameter logic [15:0] PART_CODE       = 16'h5a3c, // arbitrary value
  parameter logic [7:0]  PART_REVISION   = 8'h07,   // arbitrary value
  parameter logic [15:0] MAKER_CODE      = 16'h1234 // arbitrary value
) (
  input  wire logic       clk,                     // system clock, 25 MHz
  input  wire logic       srst,                    // synchronous reset, active high
  input  wire logic       spi_sclk,                // serial clock from host
  input  wire logic       spi_csb,                 // chip select, active low
  input  wire logic       spi_sdi,                 // serial data in
  output var  logic       spi_sdo,                 // serial data out
  output var  logic       spi_sdo_oe,              // high while sdo is driven
  input  wire logic       ref_pulse_in,            // reference pulse input
  output var  logic       ref_pulse_detect,        // gated reference pulse
  output var  logic       ref_idle_low,            // idle low, negative offset
  output var  logic       ref_idle_high,           // idle high, positive offset
  output var  logic [1:0] serial_out_level_select, // sdo swing code
  output var  logic       sample_format_select,    // 1 = two's complement
  output var  logic       sleep_mode,              // sleep, fast resume
  output var  logic       power_down_mode,         // power-down, slow resume
  output var  logic       calib_start,             // one-cycle calibration request
  output var  logic       sample_strobe            // divided sample enable
);

  // serial engine state
  acb_pkg::acb_spi_state_e state;
  logic        sclk_q;
  logic        sclk_rise;
  logic [3:0]  bit_cnt;
  logic [14:0] hdr_shift;
  logic [14:0] addr;
  logic        is_read;
  logic [7:0]  rd_shift;
  logic [6:0]  wr_shift;
  logic        hdr_done;
  logic        byte_done;
  logic [14:0] addr_next;
  logic [14:0] hdr_addr;

  // register write port
  logic        wr_en;
  logic [7:0]  wr_data;
  logic        soft_rst;

  // stored register contents
  logic        iface_rsvd6;
  logic        address_step_up;
  logic [7:0]  pwr_reg;
  logic [3:0]  class_hi;
  logic [7:0]  level_reg;
  logic [7:0]  om1_reg;
  logic [7:0]  om2_reg;
  logic        was_power_down;

  // interface_config as seen by the host
  function automatic logic [7:0] iface_view(input logic rsvd6, input logic step_up);
    logic [3:0] hi;
    hi = {1'b0, rsvd6, step_up, 1'b1};
    // low nibble is the bit-reverse of the high nibble
    iface_view = {hi, hi[0], hi[1], hi[2], hi[3]};
  endfunction

  // read decode, used for the first byte and each streamed byte
  function automatic logic [7:0] read_byte(input logic [14:0] a);
    case (a)
      acb_pkg::ADDR_IFACE:    read_byte = iface_view(iface_rsvd6, address_step_up);
      acb_pkg::ADDR_PWR:      read_byte = pwr_reg;
      acb_pkg::ADDR_CLASS:    read_byte = {class_hi, PART_CLASS_CODE};
      acb_pkg::ADDR_PART_LO:  read_byte = PART_CODE[7:0];
      acb_pkg::ADDR_PART_HI:  read_byte = PART_CODE[15:8];
      acb_pkg::ADDR_REVISION: read_byte = PART_REVISION;
      acb_pkg::ADDR_MAKER_LO: read_byte = MAKER_CODE[7:0];
      acb_pkg::ADDR_MAKER_HI: read_byte = MAKER_CODE[15:8];
      acb_pkg::ADDR_LEVEL:    read_byte = level_reg;
      acb_pkg::ADDR_OM1:      read_byte = om1_reg;
      acb_pkg::ADDR_OM2:      read_byte = om2_reg;
      default:                read_byte = 8'h00;
    endcase
  endfunction

  // serial edge and frame position decode
  always_comb begin
    sclk_rise = spi_sclk & ~sclk_q & ~spi_csb;
    hdr_done  = sclk_rise && (state != acb_pkg::ACB_DATA) && (bit_cnt == acb_pkg::HDR_LAST);
    byte_done = sclk_rise && (state == acb_pkg::ACB_DATA) && (bit_cnt == acb_pkg::DATA_LAST);
    hdr_addr  = {hdr_shift[13:0], spi_sdi};
    if (address_step_up) begin
      addr_next = addr + 15'h0001;
    end else begin
      addr_next = addr - 15'h0001;
    end
  end

  // a write lands when the last bit of a data byte is clocked in
  always_comb begin
    wr_en    = byte_done & ~is_read;
    wr_data  = {wr_shift, spi_sdi};
    soft_rst = wr_en && (addr == acb_pkg::ADDR_IFACE) && wr_data[acb_pkg::IFACE_SRST_BIT];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= spi_sclk;
    end
  end

  // frame engine: header of sixteen bits, then bytes until csb rises
  always_ff @(posedge clk) begin
    if (srst || spi_csb) begin
      state     <= acb_pkg::ACB_IDLE;
      bit_cnt   <= 4'h0;
      hdr_shift <= 15'h0000;
    end else begin
      case (state)
        // idle also takes bits, so a rise with csb's fall is not lost
        acb_pkg::ACB_IDLE, acb_pkg::ACB_HEADER: begin
          if (sclk_rise) begin
            hdr_shift <= hdr_addr;
            if (hdr_done) begin
              state   <= acb_pkg::ACB_DATA;
              bit_cnt <= 4'h0;
            end else begin
              state   <= acb_pkg::ACB_HEADER;
              bit_cnt <= bit_cnt + 4'h1;
            end
          end else begin
            state <= acb_pkg::ACB_HEADER;
          end
        end
        acb_pkg::ACB_DATA: begin
          if (byte_done) begin
            bit_cnt <= 4'h0;
          end else if (sclk_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        default: begin
          state   <= acb_pkg::ACB_IDLE;
          bit_cnt <= 4'h0;
        end
      endcase
    end
  end

  // address, direction and data shifters
  always_ff @(posedge clk) begin
    if (srst) begin
      addr     <= 15'h0000;
      is_read  <= 1'b0;
      rd_shift <= 8'h00;
      wr_shift <= 7'h00;
    end else if (hdr_done) begin
      addr     <= hdr_addr;
      is_read  <= hdr_shift[acb_pkg::HDR_RW_BIT - 1];
      rd_shift <= read_byte(hdr_addr);
    end else if (byte_done) begin
      // streaming: next byte comes from the stepped address
      addr     <= addr_next;
      rd_shift <= read_byte(addr_next);
      wr_shift <= 7'h00;
    end else if (sclk_rise && (state == acb_pkg::ACB_DATA)) begin
      // host samples on the rise, so advancing after it is safe
      rd_shift <= {rd_shift[6:0], 1'b0};
      wr_shift <= {wr_shift[5:0], spi_sdi};
    end
  end

  // register file; soft reset shares the hard reset path
  always_ff @(posedge clk) begin
    if (srst || soft_rst) begin
      iface_rsvd6     <= acb_pkg::IFACE_RST[acb_pkg::IFACE_RSVD6_BIT];
      address_step_up <= acb_pkg::IFACE_RST[acb_pkg::IFACE_STEP_BIT];
      pwr_reg         <= acb_pkg::PWR_RST;
      class_hi        <= acb_pkg::CLASS_HI_RST;
      level_reg       <= acb_pkg::LEVEL_RST;
      om1_reg         <= acb_pkg::OM1_RST;
      om2_reg         <= acb_pkg::OM2_RST;
    end else if (wr_en) begin
      case (addr)
        // soft reset bit is never stored, so it always reads back zero
        acb_pkg::ADDR_IFACE: begin
          iface_rsvd6     <= wr_data[acb_pkg::IFACE_RSVD6_BIT];
          address_step_up <= wr_data[acb_pkg::IFACE_STEP_BIT];
        end
        // a power change writes only its own register
        acb_pkg::ADDR_PWR:   pwr_reg   <= wr_data;
        acb_pkg::ADDR_CLASS: class_hi  <= wr_data[7:4];
        acb_pkg::ADDR_LEVEL: level_reg <= wr_data;
        acb_pkg::ADDR_OM1:   om1_reg   <= wr_data;
        acb_pkg::ADDR_OM2:   om2_reg   <= wr_data;
        default: ;
      endcase
    end
  end

  // serial output: driven only while a read is in its data bytes
  always_ff @(posedge clk) begin
    if (srst) begin
      spi_sdo    <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else begin
      spi_sdo    <= rd_shift[7];
      spi_sdo_oe <= ~spi_csb && is_read && (state == acb_pkg::ACB_DATA);
    end
  end

  // swing follows the register; host must set it before any read
  always_ff @(posedge clk) begin
    if (srst) begin
      serial_out_level_select <= acb_pkg::LEVEL_RST[1:0];
    end else begin
      serial_out_level_select <= level_reg[1:0];
    end
  end

  // data path and reference pulse controls
  always_ff @(posedge clk) begin
    if (srst) begin
      sample_format_select <= acb_pkg::OM1_RST[acb_pkg::OM1_FMT_BIT];
      ref_idle_low         <= 1'b0;
      ref_idle_high        <= 1'b0;
      ref_pulse_detect     <= 1'b0;
    end else begin
      sample_format_select <= om1_reg[acb_pkg::OM1_FMT_BIT];
      // reserved idle code falls back to no offset
      ref_idle_low  <= om1_reg[acb_pkg::OM1_IDLE_LSB +: 2] == acb_pkg::IDLE_LOW;
      ref_idle_high <= om1_reg[acb_pkg::OM1_IDLE_LSB +: 2] == acb_pkg::IDLE_HIGH;
      ref_pulse_detect <= ref_pulse_in & om1_reg[acb_pkg::OM1_GATE_BIT];
    end
  end

  // power state; reserved code 01 is treated as normal operation
  always_ff @(posedge clk) begin
    if (srst) begin
      sleep_mode      <= 1'b0;
      power_down_mode <= 1'b0;
      was_power_down  <= 1'b0;
      calib_start     <= 1'b0;
    end else begin
      sleep_mode      <= pwr_reg[1:0] == acb_pkg::PWR_SLEEP;
      power_down_mode <= pwr_reg[1:0] == acb_pkg::PWR_DOWN;
      was_power_down  <= pwr_reg[1:0] == acb_pkg::PWR_DOWN;
      // only the exit from power-down asks for calibration, not sleep
      calib_start     <= was_power_down && (pwr_reg[1:0] != acb_pkg::PWR_DOWN);
    end
  end

  acb_clk_div u_clk_div (
    .clk           (clk),
    .srst          (srst),
    .ratio         (om2_reg[acb_pkg::OM2_DIV_LSB +: 2]),
    .sample_strobe (sample_strobe)
  );

endmodule // acb_reg_bank

`default_nettype wire

// >>> acb_reg_bank_props.sv
// Purpose: port-level checks on the converter configuration register bank
// Assumes: single clock domain, synchronous active-high reset
// Notes:   bound to every acb_reg_bank instance
`timescale 1ns/10ps
`default_nettype none

module acb_reg_bank_props (
  input  wire logic       clk,                     // system clock
  input  wire logic       srst,                    // synchronous reset
  input  wire logic       spi_csb,                 // chip select, active low
  input  wire logic       spi_sdo_oe,              // sdo drive enable
  input  wire logic       ref_pulse_in,            // reference pulse input
  input  wire logic       ref_pulse_detect,        // gated reference pulse
  input  wire logic       ref_idle_low,            // idle low offset
  input  wire logic       ref_idle_high,           // idle high offset
  input  wire logic [1:0] serial_out_level_select, // sdo swing code
  input  wire logic       sample_format_select,    // output format
  input  wire logic       sleep_mode,              // sleep state
  input  wire logic       power_down_mode,         // power-down state
  input  wire logic       calib_start,             // calibration pulse
  input  wire logic       sample_strobe            // divided sample enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // cycles since last strobe, saturating so a stuck divider still fails
  logic [3:0] gap;
  always_ff @(posedge clk) begin
    if (srst || sample_strobe) gap <= 4'h0;
    else if (gap != 4'hf) gap <= gap + 4'h1;
  end

  property p_oe_idle;
    spi_csb [*3] |-> !spi_sdo_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("sdo driven while deselected");
  property p_oe_rise;
    $rose(spi_sdo_oe) |-> !spi_csb;
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("sdo enabled outside a frame");
  property p_oe_hold;
    spi_sdo_oe && !spi_csb |=> spi_sdo_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("sdo enable dropped inside read");
  property p_detect;
    ref_pulse_detect |-> $past(ref_pulse_in);
  endproperty
  a_detect: assert property (p_detect)
    else $error("pulse detected without input");
  property p_idle_excl;
    !(ref_idle_low && ref_idle_high);
  endproperty
  a_idle_excl: assert property (p_idle_excl)
    else $error("both idle offsets active");
  property p_pwr_excl;
    !(sleep_mode && power_down_mode);
  endproperty
  a_pwr_excl: assert property (p_pwr_excl)
    else $error("sleep and power-down together");
  property p_calib_cause;
    calib_start |-> !power_down_mode && ($past(power_down_mode) || $past(power_down_mode, 2));
  endproperty
  a_calib_cause: assert property (p_calib_cause)
    else $error("calibration without power-down exit");
  property p_calib_pulse;
    calib_start |=> !calib_start;
  endproperty
  a_calib_pulse: assert property (p_calib_pulse)
    else $error("calibration request longer than one cycle");
  property p_level_quiet;
    $changed(serial_out_level_select) |-> !spi_csb || $past(srst);
  endproperty
  a_level_quiet: assert property (p_level_quiet)
    else $error("level changed outside a frame");
  property p_format_quiet;
    $changed(sample_format_select) |-> !spi_csb || $past(srst);
  endproperty
  a_format_quiet: assert property (p_format_quiet)
    else $error("format changed outside a frame");
  property p_strobe_gap;
    gap <= 4'h8;
  endproperty
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("sample strobe gap above eight");
endmodule // acb_reg_bank_props

bind acb_reg_bank acb_reg_bank_props u_props (
  .clk(clk), .srst(srst), .spi_csb(spi_csb), .spi_sdo_oe(spi_sdo_oe),
  .ref_pulse_in(ref_pulse_in), .ref_pulse_detect(ref_pulse_detect),
  .ref_idle_low(ref_idle_low), .ref_idle_high(ref_idle_high),
  .serial_out_level_select(serial_out_level_select),
  .sample_format_select(sample_format_select), .sleep_mode(sleep_mode),
  .power_down_mode(power_down_mode), .calib_start(calib_start),
  .sample_strobe(sample_strobe));

`default_nettype wire

// >>> acb_host_model.sv
// Purpose: serial host model driving frames into the register bank
// Assumes: sclk phases of three clk cycles, changes at falling clk edge
// Notes:   sclk stands low between frames
`timescale 1ns/10ps
`default_nettype none

module acb_host_model (
  input  wire logic clk,      // system clock
  input  wire logic spi_sdo,  // serial data from device
  output var  logic spi_sclk, // serial clock
  output var  logic spi_csb,  // chip select, active low
  output var  logic spi_sdi   // serial data to device
);
  logic [7:0] wb [4];
  logic [7:0] rb [4];

  initial begin
    spi_sclk = 1'b0;
    spi_csb  = 1'b1;
    spi_sdi  = 1'b0;
  end

  task automatic bit_x(input logic b, output logic r);
    spi_sclk <= 1'b0;
    spi_sdi  <= b;
    repeat (3) @(negedge clk);
    r = spi_sdo;
    spi_sclk <= 1'b1;
    repeat (3) @(negedge clk);
  endtask

  task automatic xfer(input logic rw, input logic [14:0] a, input int n);
    logic [15:0] h;
    logic        r;
    h = {rw, a};
    @(negedge clk);
    spi_csb <= 1'b0;
    for (int i = 15; i >= 0; i--) bit_x(h[i], r);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) bit_x(wb[k][i], rb[k][i]);
    end
    spi_sclk <= 1'b0;
    // hold select until the written byte reaches the outputs
    repeat (4) @(negedge clk);
    spi_csb <= 1'b1;
    spi_sdi <= ~spi_sdi;
    repeat (4) @(negedge clk);
  endtask
endmodule // acb_host_model

`default_nettype wire

// >>> acb_reg_bank_tb_top.sv
// Purpose: self-checking bench for the register bank
// Assumes: host model drives the serial port
// Notes:   register table rows first, then streaming, gate, power, resets
`timescale 1ns/10ps
`default_nettype none

module acb_reg_bank_tb_top;
  logic       clk, srst, ref_pulse_in;
  logic       spi_sclk, spi_csb, spi_sdi, spi_sdo, spi_sdo_oe;
  logic       ref_pulse_detect, ref_idle_low, ref_idle_high;
  logic [1:0] serial_out_level_select;
  logic       sample_format_select, sleep_mode, power_down_mode;
  logic       calib_start, sample_strobe;
  int         fails = 0;
  int         tests_run = 0;
  int         ncal = 0;
  int         noe = 0;
  int         n;
  logic [7:0] a, e;
  // {addr, write flag, write data, expected read}
  logic [31:0] rows [$] = {
    32'h0000003c, 32'h02000000, 32'h03000006, 32'h040000c3, 32'h050000a5,
    32'h0600002e, 32'h0c000019, 32'h0d00007b, 32'h10000001, 32'h12000081,
    32'h13000020, 32'h01000000, 32'h7f000000, 32'h0401ffc3, 32'h03010506,
    32'h0101aa00, 32'h10010202, 32'h10010000, 32'h10010303, 32'h10010101,
    32'h02010202, 32'h02010303, 32'h02010000, 32'h12010101, 32'h12010d0d,
    32'h12011515, 32'h12011919, 32'h12018181, 32'h13012828, 32'h13013030,
    32'h13013838, 32'h13012020, 32'h00011818, 32'h00013c3c};

  acb_reg_bank #(
    .PART_CLASS_CODE(4'h6), .PART_CODE(16'ha5c3), // arbitrary values
    .PART_REVISION(8'h2e), .MAKER_CODE(16'h7b19)  // arbitrary values
  ) dut (
    .clk(clk), .srst(srst), .spi_sclk(spi_sclk), .spi_csb(spi_csb),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .ref_pulse_in(ref_pulse_in), .ref_pulse_detect(ref_pulse_detect),
    .ref_idle_low(ref_idle_low), .ref_idle_high(ref_idle_high),
    .serial_out_level_select(serial_out_level_select),
    .sample_format_select(sample_format_select), .sleep_mode(sleep_mode),
    .power_down_mode(power_down_mode), .calib_start(calib_start),
    .sample_strobe(sample_strobe));

  acb_host_model host (
    .clk(clk), .spi_sdo(spi_sdo), .spi_sclk(spi_sclk), .spi_csb(spi_csb),
    .spi_sdi(spi_sdi));

  always #20 clk = ~clk;
  always @(posedge clk) if (calib_start === 1'b1) ncal <= ncal + 1;
  // sdo enable is only seen inside a host read, so count its cycles
  always @(posedge clk) if (spi_sdo_oe === 1'b1) noe <= noe + 1;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    host.wb[0] = d;
    host.xfer(1'b0, {7'h0, ad}, 1);
  endtask

  task automatic rd(input logic [7:0] ad, input int cnt);
    host.xfer(1'b1, {7'h0, ad}, cnt);
  endtask

  // skip one strobe period so a ratio change has settled
  task automatic period(output int p);
    repeat (2) begin
      p = 0;
      @(negedge clk);
      while (sample_strobe !== 1'b1 && p < 20) begin
        @(negedge clk);
        p++;
      end
    end
    if (p >= 20) begin
      fails++;
      stop_test();
    end
  endtask

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    ref_pulse_in = 1'b0;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    wr(8'h10, 8'h01);
    chk(8'(noe), 8'h00);
    foreach (rows[i]) begin
      a = rows[i][31:24];
      e = rows[i][7:0];
      if (rows[i][16]) wr(a, rows[i][15:8]);
      rd(a, 1);
      chk(host.rb[0], e);
      case (a)
        8'h10: chk({6'h0, serial_out_level_select}, e);
        8'h02: chk({power_down_mode, sleep_mode}, {e == 8'h03, e == 8'h02});
        8'h12: chk({sample_format_select, ref_idle_high, ref_idle_low},
                   {e[7], e[4:3] == 2'h2, e[4:3] == 2'h1});
        8'h13: begin
          period(n);
          chk(8'(n + 1), 8'h1 << e[4:3]);
        end
        default: ;
      endcase
    end
    chk({7'h0, noe != 0}, 8'h01);
    chk({7'h0, spi_sdo_oe}, 8'h00);
    host.wb[0] = 8'h01;
    host.wb[1] = 8'h28;
    host.xfer(1'b0, 15'h0012, 2);
    rd(8'h12, 2);
    chk(host.rb[0], 8'h01);
    chk(host.rb[1], 8'h28);
    wr(8'h00, 8'h18);
    rd(8'h13, 2);
    chk(host.rb[0], 8'h28);
    chk(host.rb[1], 8'h01);
    host.wb[0] = 8'h20;
    host.wb[1] = 8'h81;
    host.xfer(1'b0, 15'h0013, 2);
    wr(8'h00, 8'h3c);
    rd(8'h12, 2);
    chk(host.rb[0], 8'h81);
    chk(host.rb[1], 8'h20);
    ref_pulse_in = 1'b1;
    repeat (3) @(negedge clk);
    chk({7'h0, ref_pulse_detect}, 8'h00);
    wr(8'h12, 8'h85);
    chk({7'h0, ref_pulse_detect}, 8'h01);
    ref_pulse_in = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h0, ref_pulse_detect}, 8'h00);
    wr(8'h10, 8'h02);
    wr(8'h02, 8'h03);
    rd(8'h10, 1);
    chk(host.rb[0], 8'h02);
    wr(8'h02, 8'h00);
    chk(8'(ncal), 8'h02);
    wr(8'h02, 8'h03);
    wr(8'h00, 8'hbd);
    rd(8'h00, 3);
    chk(host.rb[0], 8'h3c);
    chk(host.rb[1], 8'h00);
    chk(host.rb[2], 8'h00);
    chk({6'h0, serial_out_level_select}, 8'h01);
    chk(8'(ncal), 8'h03);
    wr(8'h10, 8'h03);
    wr(8'h12, 8'h01);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk({5'h0, sample_format_select, serial_out_level_select}, 8'h05);
    stop_test();
  end
endmodule // acb_reg_bank_tb_top

`default_nettype wire
